// [core/acf_cfg.svh]
// Constants for the ASCII command checksum framer
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH
`define ACF_PCFG_RST 9'h001
`define ACF_CH_BRACE 8'h7B
`define ACF_CH_CR 8'h0D
`define ACF_CH_NACK 8'h3F
`define ACF_CH_ZERO 8'h30
`define ACF_CH_ONE 8'h31
`define ACF_NACK_NONE 4'h0
`define ACF_NACK_TOO_MANY 4'h4
`define ACF_NACK_COMM 4'hA
`define ACF_NACK_NO_CS 4'hC
`define ACF_NACK_TEN 4'hA
`define ACF_MAX_CHARS 8'h40
`define ACF_ERR_CKSUM 9
`define ACF_ERR_LONG 10
`endif

// [core/acf_pkg.sv]
// Types and helpers for the ASCII command checksum framer
package acf_pkg;
   // Protocol configuration word, bit 8 down to bit 0
   typedef struct packed {
      logic full_duplex;
      logic little_endian;
      logic cs_raw;
      logic reg_3digit;
      logic adapter;
      logic cs_en;
      logic ack_all;
      logic addr_always;
      logic bit0;
   } acf_pcfg_t;

   // Link fault events, in error word order from bit 8 down to bit 0
   typedef struct packed {
      logic rx_timeout;
      logic tx_timeout;
      logic spi_opcode;
      logic tx_full;
      logic rx_full;
      logic overflow;
      logic noise;
      logic framing;
      logic parity;
   } acf_link_err_t;

   typedef enum logic [2:0] {
      TX_BODY = 3'b000,
      TX_BRACE = 3'b001,
      TX_CK_HI = 3'b010,
      TX_CK_LO = 3'b011,
      TX_CR = 3'b100,
      TX_NK_TENS = 3'b101,
      TX_NK_ONES = 3'b110
   } acf_tx_st_t;

   function automatic logic [7:0] acf_nib_to_hex(input logic [3:0] n);
      logic [7:0] w;
      w = {4'h0, n};
      return (n < 4'hA) ? w + 8'h30 : w + 8'h37;
   endfunction : acf_nib_to_hex

   // Returns {valid, nibble}; either letter case is accepted
   function automatic logic [4:0] acf_hex_to_nib(input logic [7:0] c);
      logic [7:0] d;
      d = 8'h00;
      if (c >= 8'h30 && c <= 8'h39) d = c - 8'h30;
      else if (c >= 8'h41 && c <= 8'h46) d = c - 8'h37;
      else if (c >= 8'h61 && c <= 8'h66) d = c - 8'h57;
      else return 5'h00;
      return {1'b1, d[3:0]};
   endfunction : acf_hex_to_nib
endpackage : acf_pkg

// [core/acf_framer.sv]
// Receive and transmit framing with checksum, error word and config word
// Notes on behaviour
// - Config bit 6 picks raw-byte check value when one, hex text when zero.
// - Checksum framing is active only while config bit 3 is one.
// - A brace separates the packet body from its check value.
// - Hex format sends the check value as two ASCII hex digits.
// - Raw format sends the check value as one binary byte.
// - Packet is address, command, parameters, optional brace and check, then CR.
// - Acknowledge and negative acknowledge replies never carry a check value.
// - Checksums on but packet lacks one: reply negative acknowledge code 12.
// - Checksums off but packet has one: reply negative acknowledge code 4.
// - Port error: record cause only; too many characters or bad check value: reply code 10 and record cause.
// - Error word is readable; zero means normal communication.
// - Error bits: parity 0x0001, framing 0x0002, noise 0x0004, overflow 0x0008.
// - Error bits: rx buffer full 16, tx full 0x0020, bad SPI opcode 0x0040.
// - Error bits: bad check value 0x0200, too many characters 0x0400.
// - Modbus multi-byte values are little endian when config bit 7 is one.
// - Serial link is full duplex when config bit 8 is one.
// - Protocol config is a nine-bit word, one option per bit.
// - Negative acknowledge is a question mark followed by a decimal code.
`timescale 1ns/10ps
`include "acf_cfg.svh"
module acf_framer
   import acf_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic cfg_wr_in,
   input wire logic [8:0] cfg_data_in,
   output acf_pcfg_t cfg_word_out,
   input wire logic err_rd_in,
   input acf_link_err_t link_err_in,
   output logic [15:0] err_word_out,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_byte_in,
   output logic rx_char_valid_out,
   output logic [7:0] rx_char_out,
   output logic rx_done_out,
   output logic [3:0] rx_code_out,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_last_in,
   input wire logic tx_data_in,
   output logic tx_ready_out,
   output logic ser_valid_out,
   output logic [7:0] ser_byte_out,
   input wire logic ser_ready_in,
   output logic drv_en_out,
   input wire logic [15:0] mb_word_in,
   output logic [15:0] mb_bytes_out
);
   acf_pcfg_t pcfg_r;
   logic [15:0] err_r;
   logic [15:0] err_set;
   logic [7:0] rx_sum_r;
   logic [7:0] rx_cnt_r;
   logic rx_long_r;
   logic in_ck_r;
   logic [1:0] ck_cnt_r;
   logic [7:0] ck_val_r;
   logic ck_badhex_r;
   logic rx_char_valid_r;
   logic [7:0] rx_char_r;
   logic rx_done_r;
   logic [3:0] rx_code_r;
   logic [3:0] nk_pend_r;
   logic [3:0] nk_code_r;
   acf_tx_st_t st_r;
   logic [7:0] tx_sum_r;
   logic tx_busy_r;
   logic ser_valid_r;
   logic [7:0] ser_byte_r;
   logic drv_en_r;
   logic [15:0] mb_r;
   logic rx_cr;
   logic ck_bad;
   logic [3:0] rx_code_nxt;
   logic load_ok;
   logic tx_take;
   logic nk_start;
   logic [7:0] tx_ck;
   logic [4:0] hex_nib;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pcfg_r <= `ACF_PCFG_RST;
      end else if (cfg_wr_in) begin
         pcfg_r <= cfg_data_in;
      end
   end

   assign rx_cr = rx_valid_in && rx_byte_in == `ACF_CH_CR && !(in_ck_r && pcfg_r.cs_raw
      && ck_cnt_r == 2'd0);
   assign hex_nib = acf_hex_to_nib(rx_byte_in);
   assign ck_bad = ck_badhex_r || ck_val_r != ~rx_sum_r
      || ck_cnt_r != (pcfg_r.cs_raw ? 2'd1 : 2'd2);

   always_comb begin
      rx_code_nxt = `ACF_NACK_NONE;
      if (pcfg_r.cs_en && !in_ck_r) rx_code_nxt = `ACF_NACK_NO_CS;
      else if (!pcfg_r.cs_en && in_ck_r) rx_code_nxt = `ACF_NACK_TOO_MANY;
      else if (rx_long_r || (pcfg_r.cs_en && ck_bad)) rx_code_nxt = `ACF_NACK_COMM;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_sum_r <= 8'h00;
         rx_cnt_r <= 8'h00;
         rx_long_r <= 1'b0;
         in_ck_r <= 1'b0;
         ck_cnt_r <= 2'd0;
         ck_val_r <= 8'h00;
         ck_badhex_r <= 1'b0;
      end else if (rx_cr) begin
         rx_sum_r <= 8'h00;
         rx_cnt_r <= 8'h00;
         rx_long_r <= 1'b0;
         in_ck_r <= 1'b0;
         ck_cnt_r <= 2'd0;
         ck_val_r <= 8'h00;
         ck_badhex_r <= 1'b0;
      end else if (rx_valid_in && in_ck_r) begin
         if (ck_cnt_r != 2'd3) ck_cnt_r <= ck_cnt_r + 2'd1;
         // raw byte taken whole, even if it looks like CR
         if (pcfg_r.cs_raw) begin
            ck_val_r <= rx_byte_in;
         end else begin
            ck_val_r <= {ck_val_r[3:0], hex_nib[3:0]};
            if (!hex_nib[4]) ck_badhex_r <= 1'b1;
         end
      end else if (rx_valid_in && rx_byte_in == `ACF_CH_BRACE) begin
         in_ck_r <= 1'b1;
      end else if (rx_valid_in) begin
         rx_sum_r <= rx_sum_r + rx_byte_in;
         if (rx_cnt_r == `ACF_MAX_CHARS) rx_long_r <= 1'b1;
         else rx_cnt_r <= rx_cnt_r + 8'h01;
      end
   end

   // body characters pass on, framing characters do not
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_char_valid_r <= 1'b0;
         rx_char_r <= 8'h00;
         rx_done_r <= 1'b0;
         rx_code_r <= `ACF_NACK_NONE;
      end else begin
         rx_char_valid_r <= rx_valid_in && !rx_cr && !in_ck_r
            && rx_byte_in != `ACF_CH_BRACE;
         if (rx_valid_in) rx_char_r <= rx_byte_in;
         rx_done_r <= rx_cr;
         if (rx_cr) rx_code_r <= rx_code_nxt;
      end
   end

   always_comb begin
      err_set = {7'h00, link_err_in};
      if (rx_cr && rx_code_nxt == `ACF_NACK_COMM) begin
         err_set[`ACF_ERR_LONG] = rx_long_r;
         err_set[`ACF_ERR_CKSUM] = !rx_long_r;
      end
   end

   // sticky causes; a new event beats the read clear
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         err_r <= 16'h0000;
      end else begin
         err_r <= (err_rd_in ? 16'h0000 : err_r) | err_set;
      end
   end

   // pending reply; a new failure overrides an older one
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         nk_pend_r <= `ACF_NACK_NONE;
      end else if (rx_cr && rx_code_nxt != `ACF_NACK_NONE) begin
         nk_pend_r <= rx_code_nxt;
      end else if (nk_start) begin
         nk_pend_r <= `ACF_NACK_NONE;
      end
   end

   assign load_ok = !ser_valid_r || ser_ready_in;
   assign nk_start = load_ok && st_r == TX_BODY && !tx_busy_r && nk_pend_r != 4'h0;
   assign tx_take = load_ok && st_r == TX_BODY && !nk_start && tx_valid_in;
   assign tx_ready_out = load_ok && st_r == TX_BODY && !nk_start;
   assign tx_ck = ~(tx_sum_r + tx_byte_in);

   // Transmit sequencer; the output register gives back-pressure from the link
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= TX_BODY;
         tx_sum_r <= 8'h00;
         tx_busy_r <= 1'b0;
         nk_code_r <= 4'h0;
         ser_valid_r <= 1'b0;
         ser_byte_r <= 8'h00;
      end else if (load_ok) begin
         ser_valid_r <= 1'b0;
         case (st_r)
            TX_BODY: begin
               if (nk_start) begin
                  ser_valid_r <= 1'b1;
                  ser_byte_r <= `ACF_CH_NACK;
                  nk_code_r <= nk_pend_r;
                  tx_busy_r <= 1'b1;
                  st_r <= (nk_pend_r >= `ACF_NACK_TEN) ? TX_NK_TENS : TX_NK_ONES;
               end else if (tx_take) begin
                  ser_valid_r <= 1'b1;
                  ser_byte_r <= tx_byte_in;
                  tx_sum_r <= tx_sum_r + tx_byte_in;
                  tx_busy_r <= 1'b1;
                  if (tx_last_in) begin
                     st_r <= (pcfg_r.cs_en && tx_data_in) ? TX_BRACE : TX_CR;
                     tx_sum_r <= tx_ck;
                  end
               end
            end
            TX_BRACE: begin
               ser_valid_r <= 1'b1;
               ser_byte_r <= `ACF_CH_BRACE;
               st_r <= pcfg_r.cs_raw ? TX_CK_LO : TX_CK_HI;
            end
            TX_CK_HI: begin
               ser_valid_r <= 1'b1;
               ser_byte_r <= acf_nib_to_hex(tx_sum_r[7:4]);
               st_r <= TX_CK_LO;
            end
            TX_CK_LO: begin
               ser_valid_r <= 1'b1;
               ser_byte_r <= pcfg_r.cs_raw ? tx_sum_r : acf_nib_to_hex(tx_sum_r[3:0]);
               st_r <= TX_CR;
            end
            TX_NK_TENS: begin
               ser_valid_r <= 1'b1;
               ser_byte_r <= `ACF_CH_ONE;
               nk_code_r <= nk_code_r - `ACF_NACK_TEN;
               st_r <= TX_NK_ONES;
            end
            // code digit then CR, no check value
            TX_NK_ONES: begin
               ser_valid_r <= 1'b1;
               ser_byte_r <= `ACF_CH_ZERO + {4'h0, nk_code_r};
               st_r <= TX_CR;
            end
            default: begin
               ser_valid_r <= 1'b1;
               ser_byte_r <= `ACF_CH_CR;
               tx_sum_r <= 8'h00;
               tx_busy_r <= 1'b0;
               st_r <= TX_BODY;
            end
         endcase
      end
   end

   // half duplex drives the line only while a reply is out
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         drv_en_r <= 1'b0;
         mb_r <= 16'h0000;
      end else begin
         drv_en_r <= pcfg_r.full_duplex || tx_busy_r || ser_valid_r;
         mb_r <= pcfg_r.little_endian ? {mb_word_in[7:0], mb_word_in[15:8]} : mb_word_in;
      end
   end

   assign cfg_word_out = pcfg_r;
   assign err_word_out = err_r;
   assign rx_char_valid_out = rx_char_valid_r;
   assign rx_char_out = rx_char_r;
   assign rx_done_out = rx_done_r;
   assign rx_code_out = rx_code_r;
   assign ser_valid_out = ser_valid_r;
   assign ser_byte_out = ser_byte_r;
   assign drv_en_out = drv_en_r;
   assign mb_bytes_out = mb_r;

   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   chk_nack_no_cs: assert property (rx_cr && pcfg_r.cs_en && !in_ck_r
      |=> rx_done_out && rx_code_out == 4'hC) else $error("missing check not coded 12");
   chk_nack_extra: assert property (rx_cr && !pcfg_r.cs_en && in_ck_r
      |=> rx_done_out && rx_code_out == 4'h4) else $error("extra check not coded 4");
   chk_comm_cause: assert property (rx_done_out && rx_code_out == 4'hA
      |-> err_r[9] || err_r[10]) else $error("code 10 without recorded cause");
   chk_err_clear: assert property (err_rd_in && err_set == 16'h0000
      |=> err_word_out == 16'h0000) else $error("error word not cleared");
   chk_link_err: assert property (link_err_in.overflow
      |=> err_word_out[3]) else $error("overflow not flagged");
   chk_brace_emit: assert property (load_ok && st_r == TX_BRACE
      |=> ser_valid_out && ser_byte_out == 8'h7B) else $error("brace not sent");
   chk_raw_value: assert property (load_ok && st_r == TX_CK_LO && pcfg_r.cs_raw
      |=> ser_byte_out == $past(tx_sum_r)) else $error("raw check value wrong");
   chk_hex_high: assert property (load_ok && st_r == TX_CK_HI
      |=> ser_byte_out == acf_nib_to_hex($past(tx_sum_r[7:4])))
      else $error("hex check digit wrong");
   chk_ack_plain: assert property (tx_take && tx_last_in && !tx_data_in
      |=> st_r == TX_CR ##1 (st_r == TX_BODY || !$past(load_ok)))
      else $error("ack got a check");
   chk_nack_mark: assert property (nk_start
      |=> ser_byte_out == 8'h3F) else $error("nack mark missing");
   chk_endian: assert property (pcfg_r.little_endian && !$past(cfg_wr_in)
      |=> mb_bytes_out[15:8] == $past(mb_word_in[7:0])) else $error("byte order wrong");
endmodule : acf_framer

// [verification/acf_host_model.sv]
// Host side of the serial link: sends command packets, collects reply bytes
`timescale 1ns/10ps
module acf_host_model (
   input wire logic clock_in,
   output logic rx_valid_out,
   output logic [7:0] rx_byte_out,
   input wire logic ser_valid_in,
   input wire logic [7:0] ser_byte_in,
   output logic ser_ready_out,
   input wire logic stall_in
);
   logic [7:0] got[$];
   logic tick_r;

   initial begin
      rx_valid_out = 1'b0;
      rx_byte_out = 8'hFF;
      ser_ready_out = 1'b1;
      tick_r = 1'b0;
   end

   // A slow host refuses every other cycle while stall_in is set
   always @(posedge clock_in) begin
      tick_r <= ~tick_r;
      ser_ready_out <= !stall_in || tick_r;
      if (ser_valid_in && ser_ready_out) got.push_back(ser_byte_in);
   end

   function automatic logic [7:0] hex(input logic [3:0] n, input logic lc);
      if (n < 4'hA) return 8'h30 + {4'h0, n};
      return (lc ? 8'h57 : 8'h37) + {4'h0, n};
   endfunction : hex

   // Mode 0 no check value, 1 hex upper, 2 raw byte, 3 hex lower; flip spoils it
   task automatic send_pkt(input string body, input int mode, input logic [7:0] flip);
      logic [7:0] q[$];
      logic [7:0] sum;
      sum = 8'h00;
      // inverted low byte of the body sum
      foreach (body[i]) begin
         q.push_back(body[i]);
         sum += body[i];
      end
      sum = ~sum ^ flip;
      if (mode != 0) q.push_back(8'h7B);
      if (mode == 1 || mode == 3) begin
         q.push_back(hex(sum[7:4], mode == 3));
         q.push_back(hex(sum[3:0], mode == 3));
      end
      if (mode == 2) q.push_back(sum);
      q.push_back(8'h0D);
      foreach (q[i]) begin
         @(posedge clock_in);
         rx_valid_out <= 1'b1;
         rx_byte_out <= q[i];
      end
      @(posedge clock_in);
      rx_valid_out <= 1'b0;
      rx_byte_out <= ~rx_byte_out;
   endtask : send_pkt
endmodule : acf_host_model

// [verification/tb_top.sv]
// Self-checking bench for the ASCII command checksum framer
`timescale 1ns/10ps
module tb_top;
   import acf_pkg::*;
   logic clock_in = 1'b0, rst_n_in = 1'b0, cfg_wr = 1'b0, err_rd = 1'b0;
   logic tx_valid = 1'b0, tx_last = 1'b0, tx_data = 1'b0, stall = 1'b0;
   logic rx_valid, ser_valid, ser_ready, tx_ready, drv_en, rx_cv, rx_done;
   logic [8:0] cfg_data = 9'h001;
   acf_pcfg_t cfg_word;
   acf_link_err_t link_err = '0;
   logic [15:0] err_word, mb_word = 16'h1234, mb_bytes;
   logic [7:0] rx_byte, rx_char, tx_byte = 8'h00, ser_byte;
   logic [7:0] exp_q[$];
   logic [7:0] last_char = 8'h00;
   logic [3:0] rx_code, code_seen;
   int miscompares = 0, checked = 0, done_cnt = 0, char_cnt = 0;
   string long_body;

   always #20 clock_in = ~clock_in;

   acf_framer i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .cfg_wr_in(cfg_wr),
      .cfg_data_in(cfg_data), .cfg_word_out(cfg_word), .err_rd_in(err_rd),
      .link_err_in(link_err), .err_word_out(err_word), .rx_valid_in(rx_valid),
      .rx_byte_in(rx_byte), .rx_char_valid_out(rx_cv), .rx_char_out(rx_char),
      .rx_done_out(rx_done), .rx_code_out(rx_code), .tx_valid_in(tx_valid),
      .tx_byte_in(tx_byte), .tx_last_in(tx_last), .tx_data_in(tx_data),
      .tx_ready_out(tx_ready), .ser_valid_out(ser_valid), .ser_byte_out(ser_byte),
      .ser_ready_in(ser_ready), .drv_en_out(drv_en), .mb_word_in(mb_word),
      .mb_bytes_out(mb_bytes));

   acf_host_model i_host (.clock_in(clock_in), .rx_valid_out(rx_valid),
      .rx_byte_out(rx_byte), .ser_valid_in(ser_valid), .ser_byte_in(ser_byte),
      .ser_ready_out(ser_ready), .stall_in(stall));

   always @(posedge clock_in) begin
      if (rx_done) begin
         done_cnt <= done_cnt + 1;
         code_seen <= rx_code;
      end
      if (rx_cv) char_cnt <= char_cnt + 1;
      if (rx_cv) last_char <= rx_char;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // Expected reply: text, optional raw byte (negative means none), then CR
   task automatic expect_frame(input string s, input int raw);
      foreach (s[i]) exp_q.push_back(s[i]);
      if (raw >= 0) exp_q.push_back(8'(raw));
      exp_q.push_back(8'h0D);
   endtask : expect_frame

   task automatic set_cfg(input logic [8:0] v);
      @(posedge clock_in);
      cfg_wr <= 1'b1;
      cfg_data <= v;
      @(posedge clock_in);
      cfg_wr <= 1'b0;
      @(negedge clock_in);
      check(16'(cfg_word), 16'(v));
   endtask : set_cfg

   task automatic read_err(input logic [15:0] e);
      @(posedge clock_in);
      err_rd <= 1'b1;
      @(negedge clock_in);
      check(err_word, e);
      @(posedge clock_in);
      err_rd <= 1'b0;
      @(negedge clock_in);
      check(err_word, 16'h0000);
   endtask : read_err

   task automatic chk_reply();
      int n;
      n = 0;
      while (i_host.got.size() < exp_q.size() && n < 400) begin
         @(posedge clock_in);
         n++;
      end
      repeat (4) @(posedge clock_in);
      check(16'(i_host.got.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) if (i < i_host.got.size()) check(16'(i_host.got[i]), 16'(exp_q[i]));
      exp_q.delete();
      i_host.got.delete();
   endtask : chk_reply

   task automatic rx_case(input logic [8:0] cfg, input string body, input int mode,
         input logic [7:0] flip, input logic [3:0] code, input string reply);
      int d0;
      int c0;
      set_cfg(cfg);
      d0 = done_cnt;
      c0 = char_cnt;
      i_host.send_pkt(body, mode, flip);
      repeat (3) @(posedge clock_in);
      check(16'(done_cnt - d0), 16'h0001);
      check(16'(code_seen), 16'(code));
      if (code == 4'h0) check(16'(char_cnt - c0), 16'(body.len()));
      if (code == 4'h0) check(16'(last_char), 16'(body[body.len() - 1]));
      if (code != 4'h0) expect_frame(reply, -1);
      chk_reply();
   endtask : rx_case

   // Hold each byte until the framer shows ready before the taking edge
   task automatic send_reply(input string s, input logic data);
      @(posedge clock_in);
      foreach (s[i]) begin
         tx_valid <= 1'b1;
         tx_byte <= s[i];
         tx_last <= (i == s.len() - 1);
         tx_data <= data;
         @(negedge clock_in);
         while (tx_ready !== 1'b1) @(negedge clock_in);
         @(posedge clock_in);
      end
      tx_valid <= 1'b0;
   endtask : send_reply

   initial begin
      #(40 * 40000);
      miscompares++;
      finish_test();
   end

   initial begin
      repeat (16) @(posedge clock_in);
      rst_n_in <= 1'b1;
      @(negedge clock_in);
      check(16'(cfg_word), 16'h0001);
      check(err_word, 16'h0000);
      rx_case(9'h00D, "CC", 1, 8'h00, 4'h0, "");
      rx_case(9'h00D, "1VE50", 3, 8'h00, 4'h0, "");
      rx_case(9'h04D, "CC", 2, 8'h00, 4'h0, "");
      rx_case(9'h04D, "yy", 2, 8'h00, 4'h0, "");
      rx_case(9'h00D, "CC", 0, 8'h00, 4'hC, "?12");
      rx_case(9'h001, "CC", 1, 8'h00, 4'h4, "?4");
      rx_case(9'h00D, "CC", 1, 8'h01, 4'hA, "?10");
      read_err(16'h0200);
      long_body = "";
      repeat (65) long_body = {long_body, "A"};
      rx_case(9'h00D, long_body, 1, 8'h00, 4'hA, "?10");
      read_err(16'h0400);
      for (int i = 0; i < 9; i++) begin
         @(posedge clock_in);
         link_err <= acf_link_err_t'(9'h001 << i);
         @(posedge clock_in);
         link_err <= '0;
         read_err(16'h0001 << i);
      end
      stall <= 1'b1;
      set_cfg(9'h00D);
      send_reply("CC=5", 1'b1);
      expect_frame("CC=5{07", -1);
      chk_reply();
      send_reply("VE=50", 1'b1);
      expect_frame("VE=50{C2", -1);
      chk_reply();
      send_reply("%", 1'b0);
      expect_frame("%", -1);
      chk_reply();
      set_cfg(9'h04D);
      send_reply("CC=1.2", 1'b1);
      expect_frame("CC=1.2{", 8'hAB);
      chk_reply();
      set_cfg(9'h181);
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      check(mb_bytes, 16'h3412);
      check(16'(drv_en), 16'h0001);
      set_cfg(9'h001);
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      check(mb_bytes, 16'h1234);
      check(16'(drv_en), 16'h0000);
      finish_test();
   end
endmodule : tb_top
